// ===== shared/crc_defs.vh
`ifndef CRC_DEFS_VH
`define CRC_DEFS_VH
// register offsets on the plain register port
`define CRC_ADDR_W 4
`define CRC_A_CMP1 4'h0
`define CRC_A_CMP2 4'h1
`define CRC_A_STAT 4'h2
`define CRC_A_SHARED 4'h3
`define CRC_A_WDOG 4'h4
`define CRC_A_IFLAG 4'h5
`define CRC_A_IMASK 4'h6
// comparator control fields
`define CRC_C_ON 7
`define CRC_C_OE 6
`define CRC_C_POL 5
`define CRC_C_EVH 4
`define CRC_C_EVL 3
`define CRC_C_REF 2
`define CRC_C_CHH 1
`define CRC_C_CHL 0
// reference control fields
`define CRC_R_PWR 7
`define CRC_R_OE 6
`define CRC_R_RNG 5
`define CRC_R_SRC 4
`define CRC_R_LVH 3
`define CRC_R_LVL 0
// watchdog control select bit
`define CRC_W_SEL 4
// interrupt edge codes
`define CRC_EV_NONE 2'h0
`define CRC_EV_RISE 2'h1
`define CRC_EV_FALL 2'h2
`define CRC_EV_ANY 2'h3
// reset values
`define CRC_RST_CMP 8'h00
`define CRC_RST_REF 8'h00
`define CRC_RST_PER 8'hff
`define CRC_RST_WDOG 8'h00
`define CRC_RST_FLAG 2'h0
`define CRC_RST_RDATA 8'h00
`endif

// ===== logic/crc_top.v
// Function
// - enabled comparator keeps running in sleep
// - enabled comparator interrupt wakes from sleep
// - comparator controls unchanged across sleep wake
// - reset clears both comparator controls
// - unimplemented status bits read zero
// - reference control shares address with period
// - bit seven powers reference ladder
// - bit six drives reference onto pin
// - bit five selects low or high range
// - bit four selects ladder supply
// - bits three to zero select tap
// - reference control unchanged across sleep wake
// - reset clears reference control bits
// - reference independent of comparator enables
// - comparator control field layout
// - status shows both comparator outputs
`timescale 1ns/1ps
`include "crc_defs.vh"
module crc_top (
  input wire CLK,
  input wire RST,
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire SLEEP,
  output wire WAKE,
  output wire IRQ,
  input wire CMP1_RAW,
  input wire CMP2_RAW,
  output wire CMP1_EN,
  output wire CMP2_EN,
  output wire CMP1_PIN_OE,
  output wire CMP2_PIN_OE,
  output wire CMP1_OUT,
  output wire CMP2_OUT,
  output wire CMP1_INTREF,
  output wire CMP2_INTREF,
  output wire [1:0] CMP1_INSEL,
  output wire [1:0] CMP2_INSEL,
  output wire REF_POWER_ON,
  output wire REF_PIN_OUTPUT,
  output wire REF_RANGE_LOW,
  output wire REF_SOURCE_EXT,
  output wire [3:0] REF_LEVEL,
  output wire [7:0] TIMER4_PERIOD,
  input wire PORT_F5_DIRECTION,
  output wire PORT_F5_DIRECTION_EFF
);
  reg [7:0] cmp1_ctl_r;
  reg [7:0] cmp2_ctl_r;
  reg [7:0] ref_ctl_r;
  reg [7:0] period_r;
  reg [7:0] wdog_r;
  reg [1:0] iflag_r;
  reg [1:0] imask_r;
  reg [1:0] iflag_nxt;
  reg c1_s1_r, c1_s2_r, c2_s1_r, c2_s2_r;
  reg c1_d_r, c2_d_r;
  wire [1:0] out_v;
  wire [1:0] ev;
  wire sel_ref;
  reg [7:0] rdata_nxt;

  // polarity applied after synchroniser
  function out_pol;
    input raw;
    input [7:0] ctl;
    begin
      out_pol = ctl[`CRC_C_ON] & (raw ^ ctl[`CRC_C_POL]);
    end
  endfunction

  // edge event by interrupt edge select
  function edge_ev;
    input now;
    input prev;
    input [7:0] ctl;
    reg [1:0] sel;
    begin
      sel = {ctl[`CRC_C_EVH], ctl[`CRC_C_EVL]};
      case (sel)
        `CRC_EV_RISE: edge_ev = now & ~prev;
        `CRC_EV_FALL: edge_ev = ~now & prev;
        `CRC_EV_ANY: edge_ev = now ^ prev;
        default: edge_ev = 1'b0;
      endcase
    end
  endfunction

  always @(posedge CLK) begin
    c1_s1_r <= CMP1_RAW;
    c1_s2_r <= c1_s1_r;
    c2_s1_r <= CMP2_RAW;
    c2_s2_r <= c2_s1_r;
  end

  // comparators run whether or not asleep
  assign out_v = {out_pol(c2_s2_r, cmp2_ctl_r), out_pol(c1_s2_r, cmp1_ctl_r)};
  assign ev = {edge_ev(out_v[1], c2_d_r, cmp2_ctl_r),
               edge_ev(out_v[0], c1_d_r, cmp1_ctl_r)};
  // shared address picks reference control when select set
  assign sel_ref = wdog_r[`CRC_W_SEL];

  always @(posedge CLK) begin
    if (RST) begin
      c1_d_r <= 1'b0;
      c2_d_r <= 1'b0;
    end else begin
      c1_d_r <= out_v[0];
      c2_d_r <= out_v[1];
    end
  end

  // sticky flags, set wins over write-one clear
  always @* begin
    iflag_nxt = iflag_r;
    if (WR && ADDR == `CRC_A_IFLAG)
      iflag_nxt = iflag_r & ~WDATA[1:0];
    iflag_nxt = iflag_nxt | ev;
  end

  // sleep never touches control state: no sleep term below
  always @(posedge CLK) begin
    if (RST) begin
      cmp1_ctl_r <= `CRC_RST_CMP;
      cmp2_ctl_r <= `CRC_RST_CMP;
      ref_ctl_r <= `CRC_RST_REF;
      period_r <= `CRC_RST_PER;
      wdog_r <= `CRC_RST_WDOG;
      iflag_r <= `CRC_RST_FLAG;
      imask_r <= `CRC_RST_FLAG;
    end else begin
      iflag_r <= iflag_nxt;
      if (WR) begin
        case (ADDR)
          `CRC_A_CMP1: cmp1_ctl_r <= WDATA;
          `CRC_A_CMP2: cmp2_ctl_r <= WDATA;
          `CRC_A_SHARED: begin
            if (sel_ref)
              ref_ctl_r <= WDATA;
            else
              period_r <= WDATA;
          end
          `CRC_A_WDOG: wdog_r <= WDATA;
          `CRC_A_IMASK: imask_r <= WDATA[1:0];
          default: ; // status writes ignored
        endcase
      end
    end
  end

  always @* begin
    rdata_nxt = 8'h00;
    case (ADDR)
      `CRC_A_CMP1: rdata_nxt = cmp1_ctl_r;
      `CRC_A_CMP2: rdata_nxt = cmp2_ctl_r;
      `CRC_A_STAT: rdata_nxt = {6'h00, out_v};
      `CRC_A_SHARED: rdata_nxt = sel_ref ? ref_ctl_r : period_r;
      `CRC_A_WDOG: rdata_nxt = wdog_r;
      `CRC_A_IFLAG: rdata_nxt = {6'h00, iflag_r};
      `CRC_A_IMASK: rdata_nxt = {6'h00, imask_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge CLK) begin
    if (RST)
      RDATA <= `CRC_RST_RDATA;
    else if (RD)
      RDATA <= rdata_nxt;
    else
      RDATA <= `CRC_RST_RDATA;
  end

  assign IRQ = |(iflag_r & imask_r);
  assign WAKE = SLEEP & IRQ;
  assign CMP1_EN = cmp1_ctl_r[`CRC_C_ON];
  assign CMP2_EN = cmp2_ctl_r[`CRC_C_ON];
  assign CMP1_PIN_OE = cmp1_ctl_r[`CRC_C_OE];
  assign CMP2_PIN_OE = cmp2_ctl_r[`CRC_C_OE];
  assign CMP1_OUT = out_v[0];
  assign CMP2_OUT = out_v[1];
  assign CMP1_INTREF = cmp1_ctl_r[`CRC_C_REF];
  assign CMP2_INTREF = cmp2_ctl_r[`CRC_C_REF];
  assign CMP1_INSEL = cmp1_ctl_r[`CRC_C_CHH:`CRC_C_CHL];
  assign CMP2_INSEL = cmp2_ctl_r[`CRC_C_CHH:`CRC_C_CHL];
  // reference outputs use no comparator bit
  assign REF_POWER_ON = ref_ctl_r[`CRC_R_PWR];
  assign REF_PIN_OUTPUT = ref_ctl_r[`CRC_R_OE];
  assign REF_RANGE_LOW = ref_ctl_r[`CRC_R_RNG];
  assign REF_SOURCE_EXT = ref_ctl_r[`CRC_R_SRC];
  assign REF_LEVEL = ref_ctl_r[`CRC_R_LVH:`CRC_R_LVL];
  assign TIMER4_PERIOD = period_r;
  // pin output overrides direction: 1 means input/released
  assign PORT_F5_DIRECTION_EFF = ref_ctl_r[`CRC_R_OE] | PORT_F5_DIRECTION;
endmodule

// ===== dv/crc_chk.sv
`timescale 1ns/1ps
module crc_chk (
  input wire CLK,
  input wire RST,
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire SLEEP,
  input wire WAKE,
  input wire IRQ,
  input wire CMP1_EN,
  input wire CMP1_OUT,
  input wire CMP2_OUT,
  input wire REF_PIN_OUTPUT,
  input wire [3:0] REF_LEVEL,
  input wire PORT_F5_DIRECTION,
  input wire PORT_F5_DIRECTION_EFF
);
  reg sel_r;
  always @(posedge CLK) sel_r <= RST ? 1'b0 : (WR && ADDR == 4'h4) ? WDATA[4] : sel_r;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_rw; WR && ADDR == 4'h3; endsequence
  sequence s_sr; RD && ADDR == 4'h2; endsequence
  property p_wake; WAKE == (SLEEP && IRQ); endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_stat; s_sr |=> RDATA == {6'h00, $past(CMP2_OUT), $past(CMP1_OUT)}; endproperty
  a_stat: assert property (p_stat) else $error("status");
  property p_ref; s_rw ##0 sel_r |=> REF_LEVEL == $past(WDATA[3:0]); endproperty
  a_ref: assert property (p_ref) else $error("ref write");
  property p_per; s_rw ##0 !sel_r |=> $stable(REF_LEVEL); endproperty
  a_per: assert property (p_per) else $error("period write");
  property p_pin; PORT_F5_DIRECTION_EFF == (REF_PIN_OUTPUT || PORT_F5_DIRECTION); endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_rst; $fell(RST) |-> REF_LEVEL == 4'h0 && !CMP1_EN && !REF_PIN_OUTPUT; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_on; WR && ADDR == 4'h0 |=> CMP1_EN == $past(WDATA[7]); endproperty
  a_on: assert property (p_on) else $error("enable");
  property p_hold; !WR || ADDR == 4'h2 |=> $stable(REF_LEVEL) && $stable(CMP1_EN); endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule
bind crc_top crc_chk u_chk (.*);

// ===== dv/crc_cmp_model.sv
`timescale 1ns/1ps
module crc_cmp_model (
  input wire [1:0] want,
  output reg [1:0] raw
);
  initial raw = 2'h0;
  // settles after a response delay, asleep or not
  always @(want) raw <= #6 want;
endmodule

// ===== dv/crc_top_tb.sv
`timescale 1ns/1ps
module crc_top_tb;
  reg clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, sleep = 1'b0, pdir = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00, v, i;
  reg [1:0] want = 2'h0;
  reg [7:0] expq[$];
  integer seed = 32'h68f7, failures = 0, checks_done = 0;
  wire [7:0] rdata, refv, per;
  wire [1:0] raw;
  wire wake, irq, pdeff;
  always #2 clk = ~clk;
  crc_cmp_model u_cmp (.want(want), .raw(raw));
  crc_top dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SLEEP(sleep), .WAKE(wake), .IRQ(irq), .CMP1_RAW(raw[0]),
    .CMP2_RAW(raw[1]), .CMP1_EN(), .CMP2_EN(), .CMP1_PIN_OE(), .CMP2_PIN_OE(),
    .CMP1_OUT(), .CMP2_OUT(), .CMP1_INTREF(), .CMP2_INTREF(), .CMP1_INSEL(),
    .CMP2_INSEL(), .REF_POWER_ON(refv[7]), .REF_PIN_OUTPUT(refv[6]),
    .REF_RANGE_LOW(refv[5]), .REF_SOURCE_EXT(refv[4]), .REF_LEVEL(refv[3:0]),
    .TIMER4_PERIOD(per), .PORT_F5_DIRECTION(pdir), .PORT_F5_DIRECTION_EFF(pdeff));
  task chk(input [7:0] s, input [7:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("ERROR %0t got %h exp %h", $time, s, e);
      end
    end
  endtask
  task acc(input w, input [3:0] a, input [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      if (w) wr <= 1'b1;
      else rd <= 1'b1;
      if (!w) expq.push_back(d);
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // read data compared the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) chk(rdata, expq.pop_front());
  end
  initial begin
    #20000;
    failures = failures + 1;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(0, 4'h0, 8'h00);
    acc(0, 4'h3, 8'hff);
    acc(0, 4'h7, 8'h00);
    acc(1, 4'h2, 8'hff);
    acc(0, 4'h2, 8'h00);
    acc(1, 4'h4, 8'h10);
    acc(0, 4'h3, 8'h00);
    repeat (4) begin
      v = $random(seed);
      pdir <= v[0];
      acc(1, 4'h3, v);
      chk(refv, v);
      chk(pdeff, v[6] | v[0]);
    end
    acc(1, 4'h4, 8'h00);
    acc(1, 4'h3, 8'h5a);
    acc(0, 4'h3, 8'h5a);
    chk(refv, v);
    chk(per, 8'h5a);
    $display("test registers done");
    acc(1, 4'h4, 8'h10);
    acc(1, 4'h3, 8'h00);
    acc(1, 4'h4, 8'h00);
    acc(1, 4'h1, 8'h00);
    acc(1, 4'h6, 8'h02);
    sleep <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      acc(1, 4'h1, 8'h80 | (i << 3));
      want[1] <= 1'b1;
      repeat (12) @(posedge clk);
      chk(wake, i[0]);
      acc(0, 4'h1, 8'h80 | (i << 3));
      want[1] <= 1'b0;
      repeat (12) @(posedge clk);
      acc(0, 4'h5, {6'h00, |i[1:0], 1'b0});
      acc(1, 4'h5, 8'h02);
      chk(irq, 8'h00);
    end
    acc(1, 4'h6, 8'h00);
    want[1] <= 1'b1;
    repeat (12) @(posedge clk);
    chk(irq, 8'h00);
    acc(1, 4'h6, 8'h02);
    chk(wake, 8'h01);
    acc(1, 4'h0, 8'ha0);
    acc(0, 4'h2, 8'h03);
    $display("test interrupts done");
    print_verdict;
  end
endmodule
